// *** hdl/ipc_defines.vh ***
// Constants for the interrupt priority control block
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH
`define IPC_A_LVD 8'h00
`define IPC_A_CHG 8'h04
`define IPC_A_SER3 8'h08
`define IPC_A_S4TW 8'h0c
`define IPC_A_SPS4 8'h10
`define IPC_A_CC9 8'h14
`define IPC_A_CTL1 8'h18
`define IPC_A_FLAG 8'h1c
`define IPC_A_EN 8'h20
`define IPC_A_CPU 8'h24
`define IPC_A_DIS 8'h28
`define IPC_A_VEC 8'h2c
`define IPC_A_IST 8'h30
`define IPC_A_IMSK 8'h34
`define IPC_AW 8
`define IPC_NSRC 14
`define IPC_NTRAP 8
`define IPC_PRIO_RST 3'h4
`define IPC_PRIO_TOP 3'h7
`define IPC_NEST_BIT 15
`define IPC_M_LVD 16'h0007
`define IPC_M_CHG 16'h0070
`define IPC_M_SER3 16'h7770
`define IPC_M_S4TW 16'h7077
`define IPC_M_SPS4 16'h7777
`define IPC_M_CC9 16'h0077
`define IPC_R_LVD 16'h0004
`define IPC_R_CHG 16'h0040
`define IPC_R_SER3 16'h4440
`define IPC_R_S4TW 16'h4044
`define IPC_R_SPS4 16'h4444
`define IPC_R_CC9 16'h0044
`define IPC_HT_NONSEQ 2'h2
`define IPC_HT_SEQ 2'h3
`endif

// *** hdl/ipc_priority_ctrl.v ***
// Interrupt priority control with AHB-Lite register access
`timescale 1ns/1ps
`include "ipc_defines.vh"

// Operation
// [R1] Priority field value is the level, seven highest, one lowest enabled
// [R2] Zero priority field disables its source entirely
// [R3] Reset puts every priority field at level four
// [R4] Bits without a field ignore writes and read zero
// [R5] Nesting disable bit fifteen stops handlers being pre-empted
// [R6] Source requests only with flag, enable and nonzero priority
// [R7] Flag left set re-requests at once after return
// [R8] Return restores the level stacked at interrupt entry
// [R9] Trap flags sit in control one; a set flag re-enters
// [R10] CPU level seven blocks all user interrupts
// [R11] Traps at levels eight to fifteen are never masked; the code still holds a trap not above the CPU level and under nesting disable
// [R12] Timed disable blocks levels one to six for a count
// [R13] Equal nonzero priorities are all serviceable
// [R14] Low-voltage field in bits two to zero
// [R15] Serial three tx 14:12, rx 10:8, error 6:4
// [R16] Serial four error 14:12, master 6:4, slave 2:0
// [R17] Event 14:12, fault 10:8, serial four tx 6:4, rx 2:0
// [R18] Capture nine 6:4, compare nine 2:0
// [R19] Present highest pending source above the CPU level
module ipc_priority_ctrl (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [13:0] src_event,
    input wire [7:0] trap_event,
    input wire irq_ack,
    input wire irq_return,
    output reg irq_req,
    output reg [4:0] irq_vector,
    output reg [3:0] irq_level,
    output reg [3:0] cpu_level,
    output reg irq_out
);

////////////////////////////////////////////////////////////////////////
reg [15:0] prio_lvd, prio_chg, prio_ser3, prio_s4tw, prio_sps4, prio_cc9;
reg nesting_disable;
reg [7:0] trap_flag;
reg [13:0] src_flag, src_en;
reg [3:0] saved_level [0:15];
reg [3:0] stack_ptr;
reg [15:0] dis_count;
reg [1:0] ev_status, ev_mask;
reg ph_wr;
reg [`IPC_AW-1:0] ph_addr;
// Reads are decoded in the address phase so data stands in the data phase
wire bus_rd;
wire [`IPC_AW-1:0] rd_addr;
assign bus_rd = hready && hsel && htrans[1] && !hwrite;
assign rd_addr = haddr[`IPC_AW-1:0];
reg [41:0] prio_vec;
reg [4:0] next_vec;
reg [3:0] next_lvl;
reg next_req;
reg [3:0] lvl_i;
integer i;

// Masked write keeps unimplemented bits at zero
function [15:0] wmask;
    input [15:0] d;
    input [15:0] m;
    begin
        wmask = d & m;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Priority field map; every source indexed 0..13
always @* begin
    prio_vec[2:0] = prio_lvd[2:0];   // [R14]
    prio_vec[5:3] = prio_chg[6:4];
    prio_vec[8:6] = prio_ser3[14:12];   // [R15]
    prio_vec[11:9] = prio_ser3[10:8];
    prio_vec[14:12] = prio_ser3[6:4];
    prio_vec[17:15] = prio_s4tw[14:12];   // [R16]
    prio_vec[20:18] = prio_s4tw[6:4];
    prio_vec[23:21] = prio_s4tw[2:0];
    prio_vec[26:24] = prio_sps4[14:12];   // [R17]
    prio_vec[29:27] = prio_sps4[10:8];
    prio_vec[32:30] = prio_sps4[6:4];
    prio_vec[35:33] = prio_sps4[2:0];
    prio_vec[38:36] = prio_cc9[6:4];   // [R18]
    prio_vec[41:39] = prio_cc9[2:0];
end

////////////////////////////////////////////////////////////////////////
// Arbitration: traps first, then highest user level above cpu level
always @* begin
    next_req = 1'b0;
    next_vec = 5'h00;
    next_lvl = 4'h0;
    lvl_i = 4'h0;
    for (i = 0; i < `IPC_NSRC; i = i + 1) begin
        lvl_i = {1'b0, prio_vec[i*3 +: 3]};   // [R1]
        // Strict greater-than keeps the first of equal levels [R13]
        if (src_flag[i] && src_en[i] && lvl_i != 4'h0 &&   // [R2] [R6]
            lvl_i > next_lvl && lvl_i > cpu_level &&   // [R10] [R19]
            !(dis_count != 16'h0000 &&
              lvl_i != {1'b0, `IPC_PRIO_TOP})) begin   // [R12]
            next_req = 1'b1;
            next_vec = i[4:0];
            next_lvl = lvl_i;
        end
    end
    for (i = 0; i < `IPC_NTRAP; i = i + 1) begin
        // Trap level 8+i ignores every user mask [R11]
        if (trap_flag[i] && (4'h8 + i[3:0]) > cpu_level) begin   // [R9]
            next_req = 1'b1;
            next_vec = 5'h10 + {2'b00, i[2:0]};
            next_lvl = 4'h8 + i[3:0];
        end
    end
    // Nesting disable: no pre-emption while a handler is active [R5]
    if (nesting_disable && stack_ptr != 4'h0) begin
        next_req = 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        prio_lvd <= `IPC_R_LVD;   // [R3]
        prio_chg <= `IPC_R_CHG;
        prio_ser3 <= `IPC_R_SER3;
        prio_s4tw <= `IPC_R_S4TW;
        prio_sps4 <= `IPC_R_SPS4;
        prio_cc9 <= `IPC_R_CC9;
        nesting_disable <= 1'b0;
        trap_flag <= 8'h00;
        src_flag <= 14'h0000;
        src_en <= 14'h0000;
        stack_ptr <= 4'h0;
        dis_count <= 16'h0000;
        ev_status <= 2'h0;
        ev_mask <= 2'h0;
        ph_wr <= 1'b0;
        ph_addr <= 8'h00;
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        irq_req <= 1'b0;
        irq_vector <= 5'h00;
        irq_level <= 4'h0;
        cpu_level <= 4'h0;
        irq_out <= 1'b0;
        for (i = 0; i < 16; i = i + 1) begin
            saved_level[i] <= 4'h0;
        end
    end else if (clk_en) begin
        // Address phase capture
        if (hready) begin
            ph_wr <= hsel && htrans[1] && hwrite;
            ph_addr <= haddr[`IPC_AW-1:0];
        end
        if (dis_count != 16'h0000) begin
            dis_count <= dis_count - 16'h0001;   // [R12]
        end
        // Hardware sets win over software clears [R7] [R9]
        src_flag <= src_flag | src_event;
        trap_flag <= trap_flag | trap_event;
        if (ph_wr) begin
            if (ph_addr == `IPC_A_LVD) begin
                prio_lvd <= wmask(hwdata[15:0], `IPC_M_LVD);   // [R4]
            end else if (ph_addr == `IPC_A_CHG) begin
                prio_chg <= wmask(hwdata[15:0], `IPC_M_CHG);
            end else if (ph_addr == `IPC_A_SER3) begin
                prio_ser3 <= wmask(hwdata[15:0], `IPC_M_SER3);
            end else if (ph_addr == `IPC_A_S4TW) begin
                prio_s4tw <= wmask(hwdata[15:0], `IPC_M_S4TW);
            end else if (ph_addr == `IPC_A_SPS4) begin
                prio_sps4 <= wmask(hwdata[15:0], `IPC_M_SPS4);
            end else if (ph_addr == `IPC_A_CC9) begin
                prio_cc9 <= wmask(hwdata[15:0], `IPC_M_CC9);
            end else if (ph_addr == `IPC_A_CTL1) begin
                nesting_disable <= hwdata[`IPC_NEST_BIT];   // [R5]
                // Only software clears a trap flag [R9]
                trap_flag <= (trap_flag & hwdata[7:0]) | trap_event;
            end else if (ph_addr == `IPC_A_FLAG) begin
                src_flag <= (src_flag & hwdata[13:0]) | src_event;   // [R7]
            end else if (ph_addr == `IPC_A_EN) begin
                src_en <= hwdata[13:0];   // [R6]
            end else if (ph_addr == `IPC_A_CPU) begin
                cpu_level <= hwdata[3:0];   // [R10]
            end else if (ph_addr == `IPC_A_DIS) begin
                dis_count <= hwdata[15:0];   // [R12]
            end else if (ph_addr == `IPC_A_IMSK) begin
                ev_mask <= hwdata[1:0];
            end
        end
        hrdata <= 32'h00000000;
        if (bus_rd) begin
            if (rd_addr == `IPC_A_LVD) begin
                hrdata <= {16'h0000, prio_lvd};
            end else if (rd_addr == `IPC_A_CHG) begin
                hrdata <= {16'h0000, prio_chg};
            end else if (rd_addr == `IPC_A_SER3) begin
                hrdata <= {16'h0000, prio_ser3};
            end else if (rd_addr == `IPC_A_S4TW) begin
                hrdata <= {16'h0000, prio_s4tw};
            end else if (rd_addr == `IPC_A_SPS4) begin
                hrdata <= {16'h0000, prio_sps4};
            end else if (rd_addr == `IPC_A_CC9) begin
                hrdata <= {16'h0000, prio_cc9};
            end else if (rd_addr == `IPC_A_CTL1) begin
                hrdata <= {16'h0000, nesting_disable, 7'h00, trap_flag};
            end else if (rd_addr == `IPC_A_FLAG) begin
                hrdata <= {18'h00000, src_flag};
            end else if (rd_addr == `IPC_A_EN) begin
                hrdata <= {18'h00000, src_en};
            end else if (rd_addr == `IPC_A_CPU) begin
                hrdata <= {28'h0000000, cpu_level};
            end else if (rd_addr == `IPC_A_DIS) begin
                hrdata <= {16'h0000, dis_count};
            end else if (rd_addr == `IPC_A_VEC) begin
                hrdata <= {23'h000000, irq_level, irq_req, 1'b0,
                           irq_vector[2:0]};
            end else if (rd_addr == `IPC_A_IST) begin
                hrdata <= {30'h00000000, ev_status};
            end else if (rd_addr == `IPC_A_IMSK) begin
                hrdata <= {30'h00000000, ev_mask};
            end
        end
        // Interrupt entry stacks the level, return restores it [R8]
        if (irq_ack && irq_req) begin
            saved_level[stack_ptr] <= cpu_level;
            stack_ptr <= stack_ptr + 4'h1;
            cpu_level <= irq_level;
        end else if (irq_return && stack_ptr != 4'h0) begin
            stack_ptr <= stack_ptr - 4'h1;
            cpu_level <= saved_level[stack_ptr - 4'h1];
        end
        // Status: bit0 request raised, bit1 trap raised; read clears
        ev_status <= ((bus_rd && rd_addr == `IPC_A_IST) ? 2'h0 : ev_status)
                     | {|trap_event, next_req & ~irq_req};
        irq_out <= |(ev_status & ev_mask);
        irq_req <= next_req;   // [R19]
        irq_vector <= next_vec;
        irq_level <= next_lvl;
    end
end

endmodule

// *** tb/ipc_cpu_model.sv ***
// CPU side model: accepts requests, returns after a delay
`timescale 1ns/1ps
module ipc_cpu_model (
    input wire hclk,
    input wire hresetn,
    input wire serve,
    input wire [3:0] dly,
    input wire irq_req,
    output reg irq_ack,
    output reg irq_return,
    output reg [7:0] acks
);
    reg [3:0] cnt;
    reg busy;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {irq_ack, irq_return, busy, cnt, acks} <= 0;
        end else begin
            irq_ack <= 0;
            irq_return <= 0;
            // Request lags the ack by a cycle, so never ack twice
            if (!busy && serve && irq_req && !irq_ack && !irq_return) begin
                irq_ack <= 1;
                busy <= 1;
                cnt <= dly;
                acks <= acks + 8'h1;
            end else if (busy && cnt == 0) begin
                irq_return <= 1;
                busy <= 0;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// *** tb/ipc_priority_ctrl_asserts.sv ***
// Port checks for the interrupt priority control block
`timescale 1ns/1ps
`include "ipc_defines.vh"
module ipc_checker (
    input wire hclk,
    input wire hresetn,
    input wire clk_en,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire irq_ack,
    input wire irq_req,
    input wire [4:0] irq_vector,
    input wire [3:0] irq_level,
    input wire [3:0] cpu_level
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd = hsel && hready && htrans[1] && !hwrite && clk_en;
    wire usr = irq_req && irq_vector < 5'd14;
    AST_NONZERO: assert property (usr |-> irq_level != 4'h0)
        else $error("user request at level zero");
    AST_USER_MAX: assert property (usr |-> irq_level <= 4'h7)
        else $error("user level above seven");
    AST_TRAP_LVL: assert property (irq_req && irq_vector[4] |->
        irq_level == {1'b1, irq_vector[2:0]} && !irq_vector[3])
        else $error("trap level wrong");
    // Stale request for one cycle after a level change is legal
    AST_ABOVE_CPU: assert property (usr && $stable(cpu_level) &&
        !$past(irq_ack) |-> irq_level > cpu_level)
        else $error("request not above cpu level");
    AST_CPU_SEVEN: assert property (cpu_level >= 4'h7 &&
        $stable(cpu_level) && !$past(irq_ack) |-> !usr)
        else $error("user request at cpu level seven");
    AST_ACK_LVL: assert property (irq_ack && irq_req |=>
        cpu_level == $past(irq_level))
        else $error("cpu level not taken on ack");
    AST_HI_ZERO: assert property (rd && haddr[7:0] <= `IPC_A_CC9 |=>
        hrdata[31:16] == 16'h0)
        else $error("upper bits not zero");
    AST_LVD: assert property (rd && haddr[7:0] == `IPC_A_LVD |=>
        hrdata[31:3] == 29'h0)
        else $error("low voltage bits wrong");
    AST_CC9: assert property (rd && haddr[7:0] == `IPC_A_CC9 |=>
        hrdata[31:7] == 25'h0 && !hrdata[3])
        else $error("capture compare bits wrong");
endmodule
bind ipc_priority_ctrl ipc_checker chk_i (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .cpu_level(cpu_level));

// *** tb/tb_top.sv ***
// Self-checking bench for the interrupt priority control block
`timescale 1ns/1ps
`include "ipc_defines.vh"
module tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, serve = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [21:0] ev_in = 0;
    logic [7:0] acks, n;
    logic hready, irq_ack, irq_return, irq_req, irq_out;
    logic [4:0] irq_vector;
    logic [3:0] irq_level, cpu_level;
    int errors = 0, checked = 0;
    logic [7:0] ad [6] = '{`IPC_A_LVD, `IPC_A_CHG, `IPC_A_SER3,
        `IPC_A_S4TW, `IPC_A_SPS4, `IPC_A_CC9};
    logic [15:0] mk [6] = '{16'h0007, 16'h0070, 16'h7770, 16'h7077,
        16'h7777, 16'h0077};
    always #20 hclk = ~hclk;
    ipc_priority_ctrl dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .src_event(ev_in[13:0]),
        .trap_event(ev_in[21:14]), .irq_ack(irq_ack),
        .irq_return(irq_return), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_level(irq_level),
        .cpu_level(cpu_level), .irq_out(irq_out));
    ipc_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .serve(serve),
        .dly(4'h3), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_return(irq_return), .acks(acks));
    ////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= `IPC_HT_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        xfer(0, a, 0);
        chk(r, e);
    endtask
    task ev(input logic [21:0] m);
        ev_in <= m;
        @(posedge hclk);
        ev_in <= 0;
        @(posedge hclk);
    endtask
    // Request is registered a cycle after the flag, three edges suffice
    task rq(input logic [9:0] e);
        repeat (3) @(posedge hclk);
        chk(e[9] ? {22'h0, irq_req, irq_vector, irq_level}
            : {31'h0, irq_req}, {22'h0, e});
    endtask
    task wrap_up;
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1;
        for (int i = 0; i < 6; i++) begin
            rc(ad[i], {16'h0, mk[i] & 16'h4444});
            xfer(1, ad[i], 32'hffffffff);
            rc(ad[i], {16'h0, mk[i]});
        end
        xfer(1, 8'h3c, 32'hffffffff);
        rc(8'h3c, 0);
        xfer(1, `IPC_A_EN, 32'h3fff);
        xfer(1, `IPC_A_LVD, 0);
        ev(22'h1);
        rq(0);
        xfer(1, `IPC_A_LVD, 5);
        rq({1'b1, 5'd0, 4'd5});
        ev(22'h2000);
        rq({1'b1, 5'd13, 4'd7});
        xfer(1, `IPC_A_CC9, 32'h55);
        rq({1'b1, 5'd0, 4'd5});
        xfer(1, `IPC_A_CPU, 7);
        rq(0);
        ev(22'h20000);
        rq({1'b1, 5'd19, 4'd11});
        rc(`IPC_A_CTL1, 32'h8);
        xfer(1, `IPC_A_CTL1, 0);
        xfer(1, `IPC_A_CPU, 0);
        xfer(1, `IPC_A_DIS, 40);
        rq(0);
        xfer(1, `IPC_A_CC9, 32'h70);
        ev(22'h1000);
        rq({1'b1, 5'd12, 4'd7});
        xfer(1, `IPC_A_FLAG, 0);
        serve <= 1;
        ev(22'h1000);
        repeat (40) @(posedge hclk);
        chk({31'h0, acks > 8'd2}, 1);
        xfer(1, `IPC_A_FLAG, 0);
        repeat (20) @(posedge hclk);
        n = acks;
        chk(cpu_level, 0);
        repeat (20) @(posedge hclk);
        chk(acks, n);
        xfer(1, `IPC_A_IMSK, 32'h3fff);
        serve <= 0;
        xfer(0, `IPC_A_IST, 0);
        ev(22'h2);
        repeat (2) @(posedge hclk);
        chk(irq_out, 1);
        rc(`IPC_A_IST, 32'h1);
        rc(`IPC_A_IST, 0);
        repeat (2) @(posedge hclk);
        chk(irq_out, 0);
        wrap_up;
    end
endmodule
